// File: cld_char_lcd_instruction_decoder.sv
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/100ps
`include "cld_defs.svh"

module cld_char_lcd_instruction_decoder #(
  parameter int unsigned BLINK_CYCLES = `CLD_BLINK_CYCLES
) (
  input  wire logic       clk_i,                // 50 MHz clock
  input  wire logic       nrst_i,               // Synchronous reset, active low
  input  wire logic       cmd_or_data_sel_i,    // 1 data, 0 instruction
  input  wire logic       read_not_write_i,     // 1 read, 0 write
  input  wire logic       xfr_sync_i,           // Transfer strobe, active high
  input  wire logic [7:0] db_i,                 // Data bus in
  output logic      [7:0] db_o,                 // Data bus out
  output logic            db_oe_o,              // Drive data bus
  input  wire logic [6:0] scan_addr_i,          // Display scan address
  output logic      [7:0] scan_char_o,          // Character code at scan address
  output logic      [6:0] ram_pointer_o,        // Cursor / pointer
  output logic      [6:0] display_shift_o,      // Display shift offset
  output logic            internal_op_pending_o, // Busy
  output logic            screen_visible_o,     // Display on
  output logic            pointer_shown_o,      // Cursor on
  output logic            pointer_flash_o,      // Blink on
  output logic            blink_phase_o,        // Blink phase
  output logic            bus_width_sel_o,      // 1 eight-bit bus
  output logic            two_rows_o,           // 1 two-line mode
  output logic            glyph_height_o        // 1 tall font
);

  cld_pkg::cld_regs_type r_r;
  cld_pkg::cld_regs_type r_nxt;

  logic [7:0] char_text_ram [0:127];
  logic [7:0] custom_glyph_ram [0:63];

  logic       txt_we;
  logic [6:0] txt_wa;
  logic [7:0] txt_wd;
  logic       gly_we;
  logic [5:0] gly_wa;
  logic [7:0] gly_wd;

  // Text pointer step with row wrap; stepping off a row end skips the gap between rows
  function automatic logic [6:0] step_text(input logic [6:0] p, input logic up,
                                           input logic rows2);
    logic [6:0] n;
    n = up ? 7'(p + 7'h01) : 7'(p - 7'h01);
    if (!rows2) begin
      if (up && p == `CLD_ONE_LINE_END) n = 7'h00;
      if (!up && p == 7'h00) n = `CLD_ONE_LINE_END;
    end else begin
      if (up && p == `CLD_ROW1_END) n = `CLD_ROW2_START;
      if (up && p == `CLD_ROW2_END) n = 7'h00;
      if (!up && p == `CLD_ROW2_START) n = `CLD_ROW1_END;
      if (!up && p == 7'h00) n = `CLD_ROW2_END;
    end
    return n;
  endfunction

  // Pointer step for either RAM
  function automatic logic [6:0] step_ptr(input logic [6:0] p, input logic up,
                                          input logic glyph, input logic rows2);
    logic [5:0] g;
    g = up ? 6'(p[5:0] + 6'h01) : 6'(p[5:0] - 6'h01);
    if (glyph) return {1'b0, g};
    return step_text(p, up, rows2);
  endfunction

  // Display offset wraps at the line length of the active mode
  function automatic logic [6:0] step_shift(input logic [6:0] s, input logic left,
                                            input logic rows2);
    logic [6:0] len;
    logic [6:0] n;
    len = rows2 ? `CLD_TWO_LINE_LEN : `CLD_ONE_LINE_LEN;
    if (left) begin
      n = (s == 7'(len - 7'h01)) ? 7'h00 : 7'(s + 7'h01);
    end else begin
      n = (s == 7'h00) ? 7'(len - 7'h01) : 7'(s - 7'h01);
    end
    return n;
  endfunction

  logic       fall;
  logic       byte_done;
  logic [7:0] wbyte;
  logic [7:0] read_val;
  logic [6:0] p_new;
  logic [6:0] rd_addr;
  logic       rd_load;
  logic       rd_glyph;

  // Next-state logic
  always_comb begin
    r_nxt     = r_r;
    txt_we    = 1'b0;
    txt_wa    = r_r.ptr;
    txt_wd    = 8'h00;
    gly_we    = 1'b0;
    gly_wa    = r_r.ptr[5:0];
    gly_wd    = 8'h00;
    p_new     = r_r.ptr;
    rd_addr   = r_r.ptr;
    rd_load   = 1'b0;
    rd_glyph  = r_r.sel_glyph;
    byte_done = 1'b0;
    wbyte     = r_r.din_l;

    // Sample select, direction and bus while the strobe is high
    r_nxt.strobe_d = xfr_sync_i;
    if (xfr_sync_i) begin
      r_nxt.rs_l  = cmd_or_data_sel_i;
      r_nxt.rw_l  = read_not_write_i;
      r_nxt.din_l = db_i;
    end
    fall = r_r.strobe_d & ~xfr_sync_i;

    // Nibble pairing: high nibble first, byte completes on the second
    if (fall) begin
      if (r_r.width8) begin
        byte_done = 1'b1;
      end else begin
        r_nxt.nib_second = ~r_r.nib_second;
        if (!r_r.nib_second) begin
          r_nxt.nib_buf = r_r.din_l[7:4];
        end else begin
          byte_done = 1'b1;
          wbyte     = {r_r.nib_buf, r_r.din_l[7:4]};
        end
      end
    end

    // Clear fills the text RAM one cell per cycle while busy
    case (r_r.state)
      cld_pkg::CLD_CLEAR: begin
        txt_we = 1'b1;
        txt_wa = r_r.clr_addr;
        txt_wd = `CLD_SPACE_CODE;
        r_nxt.clr_addr = 7'(r_r.clr_addr + 7'h01);
        if (r_r.clr_addr == `CLD_LAST_ADDR) r_nxt.state = cld_pkg::CLD_IDLE;
      end
      default: begin
        // Writes while busy are dropped; the host is expected to poll
        if (byte_done && !r_r.rw_l && !r_r.rs_l) begin
          if (wbyte[`CLD_B_TXT_ADDR]) begin
            r_nxt.ptr       = wbyte[6:0];
            r_nxt.sel_glyph = 1'b0;
            rd_addr         = wbyte[6:0];
            rd_glyph        = 1'b0;
            rd_load         = 1'b1;
          end else if (wbyte[`CLD_B_GLY_ADDR]) begin
            r_nxt.ptr       = {1'b0, wbyte[5:0]};
            r_nxt.sel_glyph = 1'b1;
            rd_addr         = {1'b0, wbyte[5:0]};
            rd_glyph        = 1'b1;
            rd_load         = 1'b1;
          end else if (wbyte[`CLD_B_FUNC]) begin
            r_nxt.width8     = wbyte[`CLD_B_DL];
            r_nxt.nib_second = 1'b0;
            r_nxt.rows2      = wbyte[`CLD_B_N];
            r_nxt.font10     = wbyte[`CLD_B_F];
          end else if (wbyte[`CLD_B_SHIFT]) begin
            if (!wbyte[`CLD_B_SC]) begin
              p_new     = step_ptr(r_r.ptr, wbyte[`CLD_B_RL], r_r.sel_glyph,
                                   r_r.rows2);
              r_nxt.ptr = p_new;
              rd_addr   = p_new;
              rd_load   = ~r_r.sel_glyph;
            end else begin
              // Cursor follows the screen, so the pointer stays put
              r_nxt.shift = step_shift(r_r.shift, ~wbyte[`CLD_B_RL], r_r.rows2);
            end
          end else if (wbyte[`CLD_B_DISP]) begin
            r_nxt.visible   = wbyte[`CLD_B_D];
            r_nxt.cursor_on = wbyte[`CLD_B_C];
            r_nxt.flash_on  = wbyte[`CLD_B_BLK];
          end else if (wbyte[`CLD_B_ENTRY]) begin
            r_nxt.entry_inc = wbyte[`CLD_B_ID];
            r_nxt.scroll    = wbyte[`CLD_B_SH];
          end else if (wbyte[`CLD_B_HOME]) begin
            r_nxt.ptr       = 7'h00;
            r_nxt.sel_glyph = 1'b0;
            r_nxt.shift     = 7'h00;
          end else if (wbyte[`CLD_B_CLEAR]) begin
            r_nxt.ptr       = 7'h00;
            r_nxt.sel_glyph = 1'b0;
            r_nxt.shift     = 7'h00;
            r_nxt.entry_inc = 1'b1;
            r_nxt.clr_addr  = 7'h00;
            r_nxt.state     = cld_pkg::CLD_CLEAR;
          end
        end else if (byte_done && !r_r.rw_l && r_r.rs_l) begin
          // Data write into the RAM picked by the last address set, home or clear
          if (r_r.sel_glyph) begin
            gly_we = 1'b1;
            gly_wd = wbyte;
          end else begin
            txt_we = 1'b1;
            txt_wd = wbyte;
            if (r_r.scroll) begin
              r_nxt.shift = step_shift(r_r.shift, r_r.entry_inc, r_r.rows2);
            end
          end
          r_nxt.ptr = step_ptr(r_r.ptr, r_r.entry_inc, r_r.sel_glyph, r_r.rows2);
        end else if (byte_done && r_r.rw_l && r_r.rs_l) begin
          // Read register is only refreshed by address set, cursor shift or a
          // read, so a read after a write returns the old byte
          p_new     = step_ptr(r_r.ptr, r_r.entry_inc, r_r.sel_glyph, r_r.rows2);
          r_nxt.ptr = p_new;
          rd_addr   = p_new;
          rd_load   = 1'b1;
        end
      end
    endcase

    // Prefetch into the output data register
    if (rd_load) begin
      r_nxt.rd_data = rd_glyph ? custom_glyph_ram[rd_addr[5:0]] : char_text_ram[rd_addr];
    end

    // Read value, split into nibbles in narrow mode
    read_val = cmd_or_data_sel_i ? r_r.rd_data
                                 : {r_r.state != cld_pkg::CLD_IDLE, r_r.ptr};
    if (r_r.width8) begin
      r_nxt.dout = read_val;
    end else begin
      r_nxt.dout = r_r.nib_second ? {read_val[3:0], 4'h0} : {read_val[7:4], 4'h0};
    end

    // Blink timer runs freely
    if (r_r.blink_cnt == 25'(BLINK_CYCLES - 1)) begin
      r_nxt.blink_cnt = 25'h0000000;
      r_nxt.blink_ph  = ~r_r.blink_ph;
    end else begin
      r_nxt.blink_cnt = 25'(r_r.blink_cnt + 25'h0000001);
    end

    // Scan port: blank when off, full cell on blinking cursor
    if (!r_r.visible) begin
      r_nxt.scan_q = `CLD_SPACE_CODE;
    end else if (r_r.flash_on && r_r.blink_ph && !r_r.sel_glyph &&
                 scan_addr_i == r_r.ptr) begin
      r_nxt.scan_q = `CLD_FULL_CELL;
    end else begin
      r_nxt.scan_q = char_text_ram[scan_addr_i];
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      r_r           <= '0;
      r_r.state     <= cld_pkg::CLD_IDLE;
      r_r.entry_inc <= 1'b1;
      r_r.width8    <= 1'b1;
      r_r.scan_q    <= `CLD_SPACE_CODE;
    end else begin
      r_r <= r_nxt;
    end
  end

  // RAM arrays carry no reset; software clears text with the clear command
  always_ff @(posedge clk_i) begin
    if (txt_we) char_text_ram[txt_wa] <= txt_wd;
    if (gly_we) custom_glyph_ram[gly_wa] <= gly_wd;
  end

  // Bus drive only during a read strobe
  assign db_oe_o               = xfr_sync_i & read_not_write_i;
  assign db_o                  = r_r.dout;
  assign scan_char_o           = r_r.scan_q;
  assign ram_pointer_o         = r_r.ptr;
  assign display_shift_o       = r_r.shift;
  assign internal_op_pending_o = (r_r.state != cld_pkg::CLD_IDLE);
  assign screen_visible_o      = r_r.visible;
  assign pointer_shown_o       = r_r.cursor_on;
  assign pointer_flash_o       = r_r.flash_on;
  assign blink_phase_o         = r_r.blink_ph;
  assign bus_width_sel_o       = r_r.width8;
  assign two_rows_o            = r_r.rows2;
  assign glyph_height_o        = r_r.font10;

endmodule

// File: cld_char_lcd_instruction_decoder_bench.sv
`timescale 1ns/100ps
module cld_char_lcd_instruction_decoder_bench;
  logic       clk_i, nrst_i, cmd_or_data_sel_i, read_not_write_i, xfr_sync_i, db_oe_o;
  logic       internal_op_pending_o, screen_visible_o, pointer_shown_o, pointer_flash_o;
  logic       blink_phase_o, bus_width_sel_o, two_rows_o, glyph_height_o;
  logic [7:0] db_i, db_o, scan_char_o, q, cfg, ptr, shf;
  logic [6:0] scan_addr_i, ram_pointer_o, display_shift_o;
  int         errors = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  assign cfg = {screen_visible_o, pointer_shown_o, pointer_flash_o, bus_width_sel_o,
                two_rows_o, glyph_height_o, 2'b00};
  assign ptr = {1'b0, ram_pointer_o};
  assign shf = {1'b0, display_shift_o};
  // Short blink period so the flashing cursor shows within a few cycles
  cld_char_lcd_instruction_decoder #(.BLINK_CYCLES(8)) uut (
    .clk_i, .nrst_i, .cmd_or_data_sel_i, .read_not_write_i, .xfr_sync_i, .db_i, .db_o,
    .db_oe_o, .scan_addr_i, .scan_char_o, .ram_pointer_o, .display_shift_o,
    .internal_op_pending_o, .screen_visible_o, .pointer_shown_o, .pointer_flash_o,
    .blink_phase_o, .bus_width_sel_o, .two_rows_o, .glyph_height_o);
  cld_host_model host (.clk_i, .rdata_i(db_o), .rs_o(cmd_or_data_sel_i),
    .rw_o(read_not_write_i), .stb_o(xfr_sync_i), .wdata_o(db_i));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic ins(input logic [7:0] d);
    host.send(1'b0, d);
  endtask
  task automatic dat(input logic [7:0] d);
    host.send(1'b1, d);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Whole run needs well under a thousand cycles; the 20000-cycle ceiling leaves wide margin
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("wrong value at %0t ns: run timed out", $time);
      print_verdict();
    end
  end
  initial begin
    nrst_i <= 1'b0;
    scan_addr_i <= 7'h00;
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(negedge clk_i);
    chk(cfg, 8'h10);
    chk({7'h00, db_oe_o}, 8'h00);
    ins(8'h01);
    chk({7'h00, internal_op_pending_o}, 8'h01);
    // Bus drive is looked at mid-strobe, while the status read is in flight
    fork
      host.xfer(1'b0, 1'b1, 8'h00, q);
      begin
        repeat (2) @(negedge clk_i);
        chk({7'h00, db_oe_o}, 8'h01);
      end
    join
    chk({7'h00, q[7]}, 8'h01);
    ins(8'h80);
    host.xfer(1'b1, 1'b1, 8'h00, q);
    chk(q, 8'h20);
    ins(8'h06);
    ins(8'h80);
    dat(8'h41);
    dat(8'h42);
    chk(ptr, 8'h02);
    ins(8'h80);
    host.xfer(1'b1, 1'b1, 8'h00, q);
    chk(q, 8'h41);
    host.xfer(1'b1, 1'b1, 8'h00, q);
    chk(q, 8'h42);
    ins(8'h81);
    ins(8'h10);
    host.xfer(1'b1, 1'b1, 8'h00, q);
    chk(q, 8'h41);
    repeat (2) ins(8'h10);
    chk(ptr, 8'h4f);
    ins(8'h14);
    chk(ptr, 8'h00);
    ins(8'h18);
    chk(shf, 8'h01);
    ins(8'h1c);
    chk(shf, 8'h00);
    $display("test pointer and shift done");
    ins(8'h04);
    ins(8'h85);
    dat(8'h43);
    chk(ptr, 8'h04);
    ins(8'h07);
    dat(8'h44);
    chk(shf, 8'h01);
    host.xfer(1'b1, 1'b1, 8'h00, q);
    chk(shf, 8'h01);
    ins(8'h05);
    dat(8'h45);
    chk(shf, 8'h00);
    ins(8'h06);
    ins(8'h18);
    ins(8'h02);
    chk(ptr | shf, 8'h00);
    ins(8'h80);
    host.xfer(1'b1, 1'b1, 8'h00, q);
    chk(q, 8'h41);
    for (int i = 0; i < 8; i++) begin
      ins(8'h08 | 8'(i));
      chk(cfg, {3'(i), 5'h10});
    end
    ins(8'h02);
    ins(8'h0d);
    for (int i = 0; i < 40 && blink_phase_o !== 1'b1; i++) @(negedge clk_i);
    @(negedge clk_i);
    chk(scan_char_o, 8'hff);
    ins(8'h0c);
    // Scan output is registered behind the setting, so it lags one more cycle
    @(negedge clk_i);
    chk(scan_char_o, 8'h41);
    ins(8'h08);
    @(negedge clk_i);
    chk(scan_char_o, 8'h20);
    $display("test display control done");
    ins(8'h45);
    chk(ptr, 8'h05);
    dat(8'h1f);
    ins(8'h45);
    // No display shift is issued straight after this glyph read
    host.xfer(1'b1, 1'b1, 8'h00, q);
    chk(q, 8'h1f);
    for (int i = 0; i < 4; i++) begin
      ins(8'h30 | 8'(i << 2));
      chk(cfg, {4'h1, 2'(i), 2'b00});
    end
    ins(8'h28);
    chk(cfg, 8'h08);
    ins(8'ha7);
    dat(8'h5a);
    chk(ptr, 8'h40);
    ins(8'ha7);
    host.xfer(1'b1, 1'b1, 8'h00, q);
    chk(q, 8'h5a);
    host.xfer(1'b0, 1'b1, 8'h00, q);
    chk(q, 8'h40);
    ins(8'h30);
    chk(cfg, 8'h10);
    $display("test glyph and narrow bus done");
    print_verdict();
  end
endmodule

// File: cld_checker_properties.sv
`timescale 1ns/100ps
module cld_checker (
  input wire logic       clk_i,                 // Clock
  input wire logic       nrst_i,                // Reset, low
  input wire logic       cmd_or_data_sel_i,     // 1 data
  input wire logic       read_not_write_i,      // 1 read
  input wire logic       xfr_sync_i,            // Strobe
  input wire logic [7:0] db_i,                  // Bus in
  input wire logic [7:0] db_o,                  // Bus out
  input wire logic       db_oe_o,               // Bus drive
  input wire logic [6:0] ram_pointer_o,         // Pointer
  input wire logic [6:0] display_shift_o,       // Shift
  input wire logic       internal_op_pending_o, // Busy
  input wire logic       screen_visible_o,      // Display on
  input wire logic       pointer_shown_o,       // Cursor on
  input wire logic       pointer_flash_o,       // Blink on
  input wire logic       bus_width_sel_o,       // 8-bit bus
  input wire logic       two_rows_o,            // Two lines
  input wire logic       glyph_height_o         // Tall font
);
  logic       stb_q;  // Strobe, one cycle back
  logic       rs_q;   // Select, one cycle back
  logic       rw_q;   // Direction, one cycle back
  logic [7:0] db_q;   // Bus, one cycle back
  logic [7:0] db_qq;  // Bus, two cycles back
  logic [6:0] step_r; // Pointer one step on
  logic       wr_ins; // Instruction write executing
  // A transfer acts on what was seen in the last strobe-high cycle
  always_ff @(posedge clk_i) begin
    stb_q  <= xfr_sync_i;
    rs_q   <= cmd_or_data_sel_i;
    rw_q   <= read_not_write_i;
    db_q   <= db_i;
    db_qq  <= db_q;
    step_r <= db_q[2] ? ram_pointer_o + 7'h01 : ram_pointer_o - 7'h01;
  end
  // Busy writes are dropped and nibbles pair up, so both are left out
  assign wr_ins = stb_q & ~xfr_sync_i & ~rs_q & ~rw_q & ~internal_op_pending_o & bus_width_sel_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_oe; db_oe_o == (xfr_sync_i & read_not_write_i); endproperty
  a_oe: assert property (p_oe) else $error("bus enable wrong");
  property p_clear; wr_ins && db_q == 8'h01 |=> internal_op_pending_o [*8] ##[1:200]
    (!internal_op_pending_o && ram_pointer_o == 7'h00 && display_shift_o == 7'h00); endproperty
  a_clear: assert property (p_clear) else $error("clear wrong");
  property p_home; wr_ins && db_q[7:1] == 7'h01 |=> (ram_pointer_o | display_shift_o) == 7'h00;
  endproperty
  a_home: assert property (p_home) else $error("home wrong");
  property p_disp; wr_ins && db_q[7:3] == 5'h01 |=>
    {screen_visible_o, pointer_shown_o, pointer_flash_o} == db_qq[2:0]; endproperty
  a_disp: assert property (p_disp) else $error("display control wrong");
  property p_func; wr_ins && db_q[7:5] == 3'b001 |=>
    {bus_width_sel_o, two_rows_o, glyph_height_o} == db_qq[4:2]; endproperty
  a_func: assert property (p_func) else $error("function set wrong");
  property p_txt; wr_ins && db_q[7] |=> ram_pointer_o == db_qq[6:0]; endproperty
  a_txt: assert property (p_txt) else $error("text address wrong");
  property p_gly; wr_ins && db_q[7:6] == 2'b01 |=> ram_pointer_o == {1'b0, db_qq[5:0]}; endproperty
  a_gly: assert property (p_gly) else $error("glyph address wrong");
  property p_step; wr_ins && db_q[7:3] == 5'h02 && !two_rows_o && ram_pointer_o > 7'h00 &&
    ram_pointer_o < 7'h3f |=> ram_pointer_o == step_r; endproperty
  a_step: assert property (p_step) else $error("cursor step wrong");
  property p_stat; stb_q && xfr_sync_i && !rs_q && rw_q && bus_width_sel_o |->
    db_o == {$past(internal_op_pending_o), $past(ram_pointer_o)}; endproperty
  a_stat: assert property (p_stat) else $error("status read wrong");
  property p_rdns; stb_q && !xfr_sync_i && rs_q && rw_q |=> $stable(display_shift_o); endproperty
  a_rdns: assert property (p_rdns) else $error("read shifted display");
endmodule

bind cld_char_lcd_instruction_decoder cld_checker u_chk (
  .clk_i, .nrst_i, .cmd_or_data_sel_i, .read_not_write_i, .xfr_sync_i, .db_i, .db_o, .db_oe_o,
  .ram_pointer_o, .display_shift_o, .internal_op_pending_o, .screen_visible_o,
  .pointer_shown_o, .pointer_flash_o, .bus_width_sel_o, .two_rows_o, .glyph_height_o);

// File: cld_defs.svh
// Functional notes
// - Clear: fill text RAM with spaces, pointer zero, unshift, force increment.
// - Home: pointer zero and display shift undone; text RAM untouched.
// - Entry direction bit set steps pointer up, clear steps it down.
// - scroll_on_write shifts display on text writes only, direction from entry.
// - screen_visible 1 shows display, 0 blanks it keeping text RAM.
// - pointer_shown shows or hides cursor; entry direction unaffected.
// - pointer_flash alternates cursor cell between all ones and the character while text RAM is selected.
// - Glyph address command loads six bits and selects glyph RAM.
// - Cursor shift moves pointer down for direction 0, up for 1.
// - Display shift moves screen left for 0, right for 1; cursor follows.
// - bus_width_sel picks 8-bit bus when 1, 4-bit bus when 0.
// - Narrow mode moves each byte as two nibbles, high first.
// - two_rows selects one-line mode at 0, two-line mode at 1.
// - glyph_height selects 5x7 font at 0, 5x10 at 1.
// - Text address command loads seven bits; valid ranges follow line mode.
// - Instruction read returns pending flag on bit 7, pointer below.
// - Data write stores into selected RAM then steps pointer.
// - First data read without address set returns stale data.
// - Cursor shift reloads read register from text RAM like an address set, but only while text RAM is selected.
// - Each data read steps pointer in the entry direction.
// - cmd_or_data_sel high selects data, low selects instruction.
// - Strobe active high; bus sampled while strobe is high, acted on when it falls.
`ifndef CLD_DEFS_SVH
`define CLD_DEFS_SVH

`define CLD_SPACE_CODE    8'h20
`define CLD_FULL_CELL     8'hff
`define CLD_ONE_LINE_END  7'h4f
`define CLD_ROW1_END      7'h27
`define CLD_ROW2_START    7'h40
`define CLD_ROW2_END      7'h67
`define CLD_ONE_LINE_LEN  7'h50
`define CLD_TWO_LINE_LEN  7'h28
`define CLD_LAST_ADDR     7'h7f

// Instruction field positions
`define CLD_B_TXT_ADDR    7
`define CLD_B_GLY_ADDR    6
`define CLD_B_FUNC        5
`define CLD_B_SHIFT       4
`define CLD_B_DISP        3
`define CLD_B_ENTRY       2
`define CLD_B_HOME        1
`define CLD_B_CLEAR       0
`define CLD_B_DL          4
`define CLD_B_N           3
`define CLD_B_F           2
`define CLD_B_SC          3
`define CLD_B_RL          2
`define CLD_B_D           2
`define CLD_B_C           1
`define CLD_B_BLK         0
`define CLD_B_ID          1
`define CLD_B_SH          0

// Cursor blink half period
`define CLD_CLK_MHZ       50
`define CLD_BLINK_MS      400
`define CLD_BLINK_CYCLES  (`CLD_BLINK_MS * 1000 * `CLD_CLK_MHZ)

`endif

// File: cld_host_model.sv
`timescale 1ns/100ps
module cld_host_model (
  input  wire logic       clk_i,           // Clock
  input  wire logic [7:0] rdata_i,         // Bus from device
  output logic            rs_o = 1'b0,     // 1 data, 0 instruction
  output logic            rw_o = 1'b0,     // 1 read
  output logic            stb_o = 1'b0,    // Strobe
  output logic      [7:0] wdata_o = 8'h00  // Bus to device
);
  logic narrow = 1'b0; // Host copy of bus width, 1 for nibbles
  // Strobe held two cycles; read data taken at the last high edge
  task automatic pulse(input logic rs, input logic rw, input logic [7:0] d,
                       output logic [7:0] q);
    @(posedge clk_i);
    rs_o <= rs;
    rw_o <= rw;
    wdata_o <= d;
    stb_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    q = rdata_i;
    stb_o <= 1'b0;
    wdata_o <= ~d;
    repeat (2) @(negedge clk_i);
  endtask
  // Narrow bus: high nibble first, both on bits 7..4
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
                      output logic [7:0] q);
    logic [7:0] hi;
    logic [7:0] lo;
    if (narrow) begin
      pulse(rs, rw, d, hi);
      pulse(rs, rw, {d[3:0], 4'h0}, lo);
      q = {hi[7:4], lo[7:4]};
    end else begin
      pulse(rs, rw, d, q);
    end
  endtask
  // Any write waits for the busy flag, bounded so a stuck flag cannot hang
  task automatic send(input logic rs, input logic [7:0] d);
    logic [7:0] s;
    s = 8'h80;
    for (int i = 0; i < 100 && s[7] !== 1'b0; i++) xfer(1'b0, 1'b1, 8'h00, s);
    xfer(rs, 1'b0, d, s);
    if (!rs && d[7:5] == 3'b001) narrow = ~d[4];
  endtask
endmodule

// File: cld_pkg.sv
package cld_pkg;

  typedef enum logic [0:0] {
    CLD_IDLE,
    CLD_CLEAR
  } cld_state_type;

  typedef struct packed {
    cld_state_type state;
    logic          strobe_d;
    logic          rs_l;
    logic          rw_l;
    logic [7:0]    din_l;
    logic          nib_second;
    logic [3:0]    nib_buf;
    logic [6:0]    clr_addr;
    logic [6:0]    ptr;
    logic          sel_glyph;
    logic          entry_inc;
    logic          scroll;
    logic          visible;
    logic          cursor_on;
    logic          flash_on;
    logic          width8;
    logic          rows2;
    logic          font10;
    logic [6:0]    shift;
    logic [7:0]    rd_data;
    logic [7:0]    dout;
    logic [7:0]    scan_q;
    logic [24:0]   blink_cnt;
    logic          blink_ph;
  } cld_regs_type;

endpackage
